// *** logic/srds_supervisor.sv ***
// Supply reset delay supervisor: reset output sequencing with an APB register slave
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
module srds_supervisor #(
    parameter logic [1:0] VARIANT = 2'h0,
    parameter int unsigned CYCLES_PER_MS = srds_pkg::CYC_PER_MS
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [srds_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Comparator flags
    input wire logic out_below_fall,
    input wire logic out_above_rise,
    input wire logic in_below_threshold,
    input wire logic temp_above_shutdown,
    input wire logic temp_below_release,
    input wire logic current_limit_flag,
    // Processor side pins
    input wire logic delay_time_select,
    output logic reset_out_n,
    // Regulator control
    output logic regulator_enable
);
    import srds_pkg::*;

    srds_tmr_if tmr (); // Link to the delay timer

    srds_state_t state; // Supervisor state
    srds_state_t next_state; // Next supervisor state
    logic out_uv_state; // Output under-voltage with hysteresis
    logic in_uv_state; // Input supply under threshold
    logic thermal_state; // Thermal shutdown active
    logic sel_latched; // Select level caught while reset is low
    logic force_reset; // Software hold of reset
    logic [EV_W-1:0] events; // Sticky event flags
    logic [REACT_W-1:0] react_cnt; // Reaction filter count
    logic [REACT_W-1:0] next_react_cnt; // Next reaction count
    logic uv_any; // Any supply under-voltage
    logic react_hit; // Under-voltage lasted the reaction time
    logic cond_ok; // Everything good for release
    logic [7:0] delay_ms; // Selected delay in ms
    logic [31:0] delay_cyc; // Selected delay in cycles

    // APB decode
    logic setup_ph; // Setup phase of any transfer
    logic wr_en; // Write taken this edge
    logic hit_status; // Address selects status
    logic hit_control; // Address selects control
    logic hit_events; // Address selects events
    logic hit_count; // Address selects delay count
    logic mapped; // Address is one of ours
    logic [31:0] rd_mux; // Read data selection
    logic [31:0] status_word; // Status assembled
    logic [EV_W-1:0] ev_set; // Events raised this cycle
    logic [EV_W-1:0] ev_clr; // Events cleared by software

    // Delay timer instance
    srds_delay_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .tmr(tmr)
    );

    // Delay from variant pair and latched select; low select is the default
    assign delay_ms = srds_delay_ms(VARIANT, sel_latched);
    assign delay_cyc = 32'(delay_ms) * 32'(CYCLES_PER_MS);
    assign tmr.target = delay_cyc[CNT_W-1:0];
    // Timer runs only while in the delay state, otherwise held at zero
    assign tmr.run = (state == ST_DELAY);

    // Supply faults and release condition
    assign uv_any = out_uv_state || in_uv_state;
    assign cond_ok = !uv_any && !thermal_state && !force_reset;
    assign react_hit = (state == ST_RUN) && uv_any && (react_cnt == REACT_LAST);

    // Output under-voltage flag: set at the falling threshold, cleared above the rising one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_uv_state <= 1'b1;
        end else if (out_below_fall) begin
            out_uv_state <= 1'b1;
        end else if (out_above_rise) begin
            out_uv_state <= 1'b0;
        end
    end

    // Input supply flag follows its comparator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_uv_state <= 1'b1;
        end else begin
            in_uv_state <= in_below_threshold;
        end
    end

    // Thermal shutdown: trip high, release only at the lower level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thermal_state <= 1'b0;
        end else if (temp_above_shutdown) begin
            thermal_state <= 1'b1;
        end else if (temp_below_release) begin
            thermal_state <= 1'b0;
        end
    end

    // Reaction filter counts the under-voltage time while reset is high
    assign next_react_cnt = (state != ST_RUN || !uv_any) ? REACT_ZERO :
                            (react_hit ? react_cnt : react_cnt + 11'h001);

    // Reaction counter register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            react_cnt <= REACT_ZERO;
        end else begin
            react_cnt <= next_react_cnt;
        end
    end

    // Select is followed only while reset is low, frozen while high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_latched <= 1'b0;
        end else if (!reset_out_n) begin
            sel_latched <= delay_time_select;
        end
    end

    // Sequencing of reset and regulator
    always_comb begin
        next_state = state;
        case (state)
            // Reset low, wait for all conditions good
            ST_HOLD: begin
                if (thermal_state) begin
                    next_state = ST_THERMAL;
                end else if (cond_ok) begin
                    next_state = ST_DELAY;
                end
            end
            // Counting the release delay, any fault restarts it
            ST_DELAY: begin
                if (thermal_state) begin
                    next_state = ST_THERMAL;
                end else if (!cond_ok) begin
                    next_state = ST_HOLD;
                end else if (tmr.done) begin
                    next_state = ST_RUN;
                end
            end
            // Reset released; current limit plays no part here
            ST_RUN: begin
                if (thermal_state) begin
                    next_state = ST_THERMAL;
                end else if (react_hit || force_reset) begin
                    next_state = ST_HOLD;
                end
            end
            // Output off until the die cools to the release level
            ST_THERMAL: begin
                if (!thermal_state) begin
                    next_state = ST_HOLD;
                end
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase
    end

    // State and pin registers; reset held low from reset onward
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_HOLD;
            reset_out_n <= 1'b0;
            regulator_enable <= 1'b1;
        end else begin
            state <= next_state;
            reset_out_n <= (next_state == ST_RUN);
            regulator_enable <= (next_state != ST_THERMAL);
        end
    end

    // APB address decode
    assign setup_ph = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign hit_status = (paddr == OFS_STATUS);
    assign hit_control = (paddr == OFS_CONTROL);
    assign hit_events = (paddr == OFS_EVENTS);
    assign hit_count = (paddr == OFS_COUNT);
    assign mapped = hit_status || hit_control || hit_events || hit_count;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Status word
    assign status_word = {22'h000000, state, 1'b0, current_limit_flag, sel_latched,
                          thermal_state, in_uv_state, out_uv_state, regulator_enable, reset_out_n};

    // Read selection
    assign rd_mux = hit_status ? status_word :
                    hit_control ? {31'h00000000, force_reset} :
                    hit_events ? {28'h0000000, events} :
                    hit_count ? {7'h00, tmr.count} : 32'h00000000;

    // Read data captured in the setup phase, valid during access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_ph && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Control register: software hold of the reset output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_reset <= CONTROL_RST[CTB_FORCE];
        end else if (wr_en && hit_control) begin
            force_reset <= pwdata[CTB_FORCE];
        end
    end

    // Event sources and write-one-to-clear
    assign ev_set = {current_limit_flag,
                     in_uv_state && (state == ST_RUN),
                     thermal_state && (state != ST_THERMAL),
                     react_hit};
    assign ev_clr = (wr_en && hit_events) ? pwdata[EV_W-1:0] : EVENTS_RST;

    // Sticky events; a new event wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events <= EVENTS_RST;
        end else begin
            events <= (events & ~ev_clr) | ev_set;
        end
    end

    // Checks
    uv_hyst_a: assert property (@(posedge pclk) disable iff (!presetn)
        (out_uv_state && !out_above_rise) |=> out_uv_state)
        else $error("output flag cleared without rising threshold");

    react_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        react_hit |=> !reset_out_n && state == ST_HOLD)
        else $error("reset not asserted after reaction time");

    react_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
        (reset_out_n && uv_any) |-> react_cnt <= REACT_LAST)
        else $error("reaction count ran past its limit");

    release_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(reset_out_n) |-> $past(tmr.done) && $past(state) == ST_DELAY)
        else $error("reset released without full delay");

    low_select_a: assert property (@(posedge pclk) disable iff (!presetn)
        !sel_latched |-> delay_ms == ((VARIANT == 2'h2) ? DLY_16_MS : (VARIANT == 2'h3) ? DLY_32_MS : DLY_8_MS))
        else $error("low select did not give low delay");

    sel_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
        (reset_out_n && $past(reset_out_n)) |-> $stable(sel_latched))
        else $error("select changed while reset high");

    therm_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        thermal_state |-> ##1 (!regulator_enable && !reset_out_n))
        else $error("thermal trip did not shut output");

    therm_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (thermal_state && !temp_below_release) |=> thermal_state)
        else $error("thermal flag cleared above release level");

    therm_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ST_THERMAL && !thermal_state) |=> ##1 (regulator_enable && !reset_out_n))
        else $error("thermal exit sequence wrong");

    clim_no_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(reset_out_n) |-> $past(react_hit || force_reset || thermal_state))
        else $error("reset dropped without a supply cause");

    restart_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ST_DELAY && !cond_ok) |=> ##1 (tmr.count == CNT_ZERO && !reset_out_n))
        else $error("delay counter not restarted");

    // Pin levels track the sequencer state, and the run and delay stages hold while their conditions hold
    pin_state_a: assert property (@(posedge pclk) disable iff (!presetn)
        reset_out_n == (state == ST_RUN))
        else $error("reset pin out of step with state");

    reg_state_a: assert property (@(posedge pclk) disable iff (!presetn)
        regulator_enable == (state != ST_THERMAL))
        else $error("regulator enable out of step with state");

    force_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        force_reset |=> !reset_out_n)
        else $error("software hold did not keep reset low");

    run_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ST_RUN && !uv_any && !thermal_state && !force_reset) |=> state == ST_RUN)
        else $error("reset left without a supply cause");

    delay_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ST_DELAY && cond_ok && !tmr.done) |=> state == ST_DELAY)
        else $error("delay ended before its count");

    input_uv_a: assert property (@(posedge pclk) disable iff (!presetn)
        in_below_threshold |=> in_uv_state)
        else $error("input supply flag not taken");

    sel_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        !reset_out_n |=> sel_latched == $past(delay_time_select))
        else $error("select not followed while reset low");

    count_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state != ST_DELAY) |=> tmr.count == CNT_ZERO)
        else $error("delay counter not held at zero");

    react_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ST_RUN && !uv_any) |=> react_cnt == REACT_ZERO)
        else $error("reaction filter not cleared");

    therm_trip_a: assert property (@(posedge pclk) disable iff (!presetn)
        temp_above_shutdown |=> thermal_state)
        else $error("thermal trip not taken");

endmodule : srds_supervisor

// *** inc/srds_pkg.sv ***
// Constants, types and helpers shared by the supply reset delay supervisor
package srds_pkg;

    // Block clock rate
    localparam int CLK_MHZ = 125;

    // Reaction window from under-voltage to reset low, in microseconds
    localparam int REACT_MIN_US = 16;
    localparam int REACT_MAX_US = 38;

    // Reaction filter length in cycles (least time, rounded up)
    localparam int REACT_CYC = (REACT_MIN_US * CLK_MHZ * 1000 + 999) / 1000;
    localparam int REACT_W = 11;
    localparam logic [REACT_W-1:0] REACT_LAST = REACT_W'(REACT_CYC - 1);
    localparam logic [REACT_W-1:0] REACT_ZERO = 11'h000;

    // Cycles per millisecond at the block clock
    localparam int CYC_PER_MS = CLK_MHZ * 1000;

    // Release delay counter width (128 ms at 125 MHz fits)
    localparam int CNT_W = 25;
    localparam logic [CNT_W-1:0] CNT_ZERO = 25'h0000000;
    localparam logic [CNT_W-1:0] CNT_ONE = 25'h0000001;

    // Release delay pair members in milliseconds
    localparam logic [7:0] DLY_8_MS = 8'h08;
    localparam logic [7:0] DLY_16_MS = 8'h10;
    localparam logic [7:0] DLY_32_MS = 8'h20;
    localparam logic [7:0] DLY_64_MS = 8'h40;
    localparam logic [7:0] DLY_128_MS = 8'h80;

    // Register byte offsets
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_EVENTS = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 12'h00c;

    // Status field positions
    localparam int STB_RESET = 0;
    localparam int STB_REG_EN = 1;
    localparam int STB_OUT_UV = 2;
    localparam int STB_IN_UV = 3;
    localparam int STB_THERM = 4;
    localparam int STB_SEL = 5;
    localparam int STB_CLIM = 6;
    localparam int STB_STATE = 8;

    // Control field positions and value after reset
    localparam int CTB_FORCE = 0;
    localparam logic [31:0] CONTROL_RST = 32'h00000000;

    // Event field positions and value after reset
    localparam int EVB_OUT_UV = 0;
    localparam int EVB_THERM = 1;
    localparam int EVB_IN_UV = 2;
    localparam int EVB_CLIM = 3;
    localparam int EV_W = 4;
    localparam logic [EV_W-1:0] EVENTS_RST = 4'h0;

    // Supervisor states
    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN = 2'b10,
        ST_THERMAL = 2'b11
    } srds_state_t;

    // Delay in ms for a variant and a latched select level
    function automatic logic [7:0] srds_delay_ms(input logic [1:0] variant, input logic sel);
        logic [7:0] ms;
        ms = DLY_8_MS;
        case (variant)
            2'h0: ms = sel ? DLY_128_MS : DLY_8_MS;
            2'h1: ms = sel ? DLY_32_MS : DLY_8_MS;
            2'h2: ms = sel ? DLY_64_MS : DLY_16_MS;
            default: ms = sel ? DLY_128_MS : DLY_32_MS;
        endcase
        return ms;
    endfunction : srds_delay_ms

endpackage : srds_pkg

// *** inc/srds_tmr_if.sv ***
// Link between the supervisor and its release delay timer
`timescale 1ns/1ps
interface srds_tmr_if;
    import srds_pkg::*;
    logic run; // Count while high, clear while low
    logic [CNT_W-1:0] target; // Cycles to count
    logic [CNT_W-1:0] count; // Cycles counted so far
    logic done; // Last cycle of the delay
    modport ctrl (output run, output target, input count, input done);
    modport timer (input run, input target, output count, output done);
endinterface : srds_tmr_if

// *** logic/srds_delay_timer.sv ***
// Release delay counter for the supply reset delay supervisor
`timescale 1ns/1ps
module srds_delay_timer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control from the supervisor
    srds_tmr_if.timer tmr
);
    import srds_pkg::*;

    logic [CNT_W-1:0] count; // Elapsed cycles
    logic [CNT_W-1:0] next_count; // Next elapsed value
    logic last; // Count has reached the final cycle

    // Final cycle of the selected delay
    // A target that shrinks in mid-count ends the delay at once instead of wrapping
    assign last = (count >= (tmr.target - CNT_ONE));
    // Count up while running, restart from zero when stopped
    assign next_count = !tmr.run ? CNT_ZERO : (last ? count : count + CNT_ONE);

    // Counter register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= CNT_ZERO;
        end else begin
            count <= next_count;
        end
    end

    assign tmr.count = count;
    assign tmr.done = tmr.run && last;

endmodule : srds_delay_timer

// *** test/srds_proc_model.sv ***
// Processor model that receives the reset and drives the delay select pin
`timescale 1ns/1ps
module srds_proc_model (
    // Clock
    input wire logic pclk,
    // Pins facing the supervisor
    input wire logic reset_out_n,
    output logic delay_time_select,
    // Bench control and observation
    input wire logic want_long,
    output int resets_seen
);
    logic last_reset_n = 1'b0; // Reset level at the previous edge
    int seen = 0; // Falling edges of reset counted so far

    // Select is ordinary logic; the bench only moves it while reset is low or to probe freezing
    always @(posedge pclk) begin
        delay_time_select <= want_long;
    end

    // Count each assertion of reset that the processor sees
    always @(posedge pclk) begin
        last_reset_n <= reset_out_n;
        if (last_reset_n && !reset_out_n) begin
            seen <= seen + 1;
        end
    end

    assign resets_seen = seen;
endmodule : srds_proc_model

// *** test/srds_supervisor_tb.sv ***
// Self-checking testbench of the supply reset delay supervisor
`timescale 1ns/1ps
module srds_supervisor_tb;
    import srds_pkg::*;
    localparam int CPM = 10; // Shortened millisecond in cycles
    localparam int D_SHORT = 8 * CPM; // Short delay of variant 0
    localparam int D_LONG = 128 * CPM; // Long delay of variant 0
    localparam int SLACK = 8; // Pipeline cycles allowed after a delay
    localparam int REACT_MIN = 16 * CLK_MHZ; // Earliest reaction in cycles
    localparam int REACT_MAX = 38 * CLK_MHZ; // Latest reaction in cycles
    // Clock, reset and bus
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // Comparator flags, starting under-voltage
    logic out_below_fall = 1'b1;
    logic out_above_rise = 1'b0;
    logic in_below_threshold = 1'b0;
    logic temp_above_shutdown = 1'b0;
    logic temp_below_release = 1'b1;
    logic current_limit_flag = 1'b0;
    // Processor side
    logic delay_time_select;
    logic reset_out_n;
    logic regulator_enable;
    logic want_long = 1'b0;
    int resets_seen;
    // Bookkeeping
    int num_errors = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic err;

    srds_supervisor #(.VARIANT(2'h0), .CYCLES_PER_MS(CPM)) i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .out_below_fall, .out_above_rise, .in_below_threshold, .temp_above_shutdown,
        .temp_below_release, .current_limit_flag, .delay_time_select, .reset_out_n, .regulator_enable
    );

    srds_proc_model i_proc (
        .pclk, .reset_out_n, .delay_time_select, .want_long, .resets_seen
    );

    // Free-running block clock
    initial begin
        forever #4 pclk = ~pclk;
    end

    // Compare two words and report a mismatch
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Compare one bit
    task automatic chk1(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask : chk1

    // Count must fall inside a window
    task automatic check_range(input int n, input int lo, input int hi);
        check((n >= lo && n <= hi) ? lo : n, lo);
    endtask : check_range

    // Cycles until reset reaches a level, sampled on the falling edge
    task automatic wait_level(input logic lvl, input int max, output int n);
        n = 0;
        while (reset_out_n !== lvl && n < max) begin
            @(negedge pclk);
            n++;
        end
    endtask : wait_level

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wd,
                       output logic [31:0] rdata, output logic rerr);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Hysteresis band holds reset, then the short delay runs after recovery
    task automatic t_power_up();
        int n;
        @(posedge pclk);
        out_below_fall <= 1'b0;
        repeat (3 * D_SHORT) @(negedge pclk);
        chk1(reset_out_n, 1'b0);
        @(posedge pclk);
        out_above_rise <= 1'b1;
        wait_level(1'b1, D_SHORT + 20, n);
        check_range(n, D_SHORT, D_SHORT + SLACK);
        $display("Test power_up done");
    endtask : t_power_up

    // Select moves while reset is high and must not be taken
    task automatic t_select_frozen();
        @(posedge pclk);
        want_long <= 1'b1;
        repeat (10) @(negedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0, rd, err);
        chk1(rd[STB_SEL], 1'b0);
        chk1(rd[STB_RESET], 1'b1);
        $display("Test select_frozen done");
    endtask : t_select_frozen

    // Thermal trip, lingering between levels, then the long delay
    task automatic t_thermal();
        int n;
        @(posedge pclk);
        temp_above_shutdown <= 1'b1;
        temp_below_release <= 1'b0;
        wait_level(1'b0, 10, n);
        check_range(n, 0, 3);
        chk1(regulator_enable, 1'b0);
        @(posedge pclk);
        temp_above_shutdown <= 1'b0;
        repeat (2 * D_LONG) @(negedge pclk);
        chk1(regulator_enable, 1'b0);
        chk1(reset_out_n, 1'b0);
        @(posedge pclk);
        temp_below_release <= 1'b1;
        wait_level(1'b1, D_LONG + 20, n);
        check_range(n, D_LONG, D_LONG + SLACK);
        chk1(regulator_enable, 1'b1);
        $display("Test thermal done");
    endtask : t_thermal

    // Under-voltage reaction, then a glitch in mid-delay restarts the count
    task automatic t_uv_restart();
        int n;
        @(posedge pclk);
        out_below_fall <= 1'b1;
        out_above_rise <= 1'b0;
        wait_level(1'b0, REACT_MAX + 10, n);
        check_range(n, REACT_MIN, REACT_MAX);
        @(posedge pclk);
        want_long <= 1'b0;
        out_below_fall <= 1'b0;
        out_above_rise <= 1'b1;
        repeat (D_SHORT / 2) @(negedge pclk);
        @(posedge pclk);
        out_below_fall <= 1'b1;
        out_above_rise <= 1'b0;
        @(posedge pclk);
        out_below_fall <= 1'b0;
        out_above_rise <= 1'b1;
        wait_level(1'b1, D_SHORT + 20, n);
        check_range(n, D_SHORT, D_SHORT + SLACK);
        $display("Test uv_restart done");
    endtask : t_uv_restart

    // Current limit alone, then input supply under-voltage
    task automatic t_supply_flags();
        int n;
        @(posedge pclk);
        current_limit_flag <= 1'b1;
        repeat (REACT_MAX + 10) @(negedge pclk);
        chk1(reset_out_n, 1'b1);
        @(posedge pclk);
        current_limit_flag <= 1'b0;
        in_below_threshold <= 1'b1;
        wait_level(1'b0, REACT_MAX + 10, n);
        check_range(n, 1, REACT_MAX);
        @(posedge pclk);
        in_below_threshold <= 1'b0;
        wait_level(1'b1, D_SHORT + 20, n);
        check_range(n, D_SHORT, D_SHORT + SLACK);
        $display("Test supply_flags done");
    endtask : t_supply_flags

    // Forced reset, unmapped access and event clearing over the bus
    task automatic t_registers();
        int n;
        apb(1'b1, OFS_CONTROL, 32'h00000001, rd, err);
        repeat (3) @(negedge pclk);
        chk1(reset_out_n, 1'b0);
        apb(1'b0, OFS_CONTROL, 32'h0, rd, err);
        check(rd, 32'h00000001);
        apb(1'b0, 12'h010, 32'h0, rd, err);
        check({rd[30:0], err}, 32'h00000001);
        apb(1'b0, OFS_EVENTS, 32'h0, rd, err);
        check(rd, 32'h0000000f);
        apb(1'b1, OFS_EVENTS, 32'h0000000f, rd, err);
        apb(1'b0, OFS_EVENTS, 32'h0, rd, err);
        check(rd, 32'h00000000);
        apb(1'b1, OFS_CONTROL, 32'h0, rd, err);
        // Delay starts one edge after the release; 19 cycles counted when the read is set up
        repeat (20) @(negedge pclk);
        apb(1'b0, OFS_COUNT, 32'h0, rd, err);
        check(rd, 32'h00000013);
        wait_level(1'b1, D_SHORT + 20, n);
        check_range(n, D_SHORT - 22, D_SHORT - 22 + SLACK);
        check(resets_seen, 32'h00000004);
        $display("Test registers done");
    endtask : t_registers

    // Print the counts and the verdict, then stop
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    // Cut a hang short
    initial begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        $display("Watchdog expired at t=%0t", $time);
        conclude();
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_power_up();
        t_select_frozen();
        t_thermal();
        t_uv_restart();
        t_supply_flags();
        t_registers();
        conclude();
    end
endmodule : srds_supervisor_tb
